// *** src/tbpc_map.svh ***
`ifndef TBPC_MAP_SVH
`define TBPC_MAP_SVH
`define TBPC_CNT_RST 16'h0000
`define TBPC_CNT_MAX 16'hFFFF
`define TBPC_GR_RST 16'hFFFF
`define TBPC_SEL_CNT 3'h4
`define TBPC_CLR_SYNC 3'h5
`define TBPC_LVL_LOW 2'h1
`define TBPC_LVL_HIGH 2'h2
`define TBPC_LVL_TOG 2'h3
`define TBPC_PH_M1 2'h0
`define TBPC_PH_M2 2'h1
`define TBPC_PH_M3 2'h2
`endif

// *** src/tbpc_pkg.sv ***
package tbpc_pkg;
	typedef enum logic [1:0] {
		TBPC_NORMAL = 2'h0,
		TBPC_PWM1 = 2'h1,
		TBPC_PWM2 = 2'h3,
		TBPC_PHASE = 2'h2
	} tbpc_mode_t;
	typedef struct packed {
		logic run;
		logic sync;
		tbpc_mode_t mode;
		logic [1:0] phase_sel;
		logic [2:0] clr_sel;
		logic [3:0][1:0] io_lvl;
		logic [3:0] init_lvl;
		logic [1:0] buf_en;
		logic [1:0] cap_en;
		logic [1:0] cap_edge;
		logic [5:0] irq_en;
	} tbpc_cfg_t;
	typedef struct packed {
		logic we;
		logic [1:0] ch;
		logic [2:0] sel;
		logic [15:0] data;
	} tbpc_wr_t;
	typedef struct packed {
		logic [3:0] cmp;
		logic ovf;
		logic unf;
		logic dir;
	} tbpc_stat_t;
	typedef struct packed {
		logic [15:0] cnt;
		logic [3:0][15:0] gr;
		logic [3:0] pin;
		tbpc_stat_t st;
		logic irq;
	} tbpc_ch_t;
	typedef struct packed {
		tbpc_ch_t [2:0] ch;
		logic [1:0][3:0] ext_s;
		logic [3:0] ext;
		logic [1:0][2:0][1:0] cap_s;
		logic [2:0][1:0] cap;
	} tbpc_state_t;
endpackage

// *** src/tbpc_unit.sv ***
// Operation
// RQ1: Buffered compare A match drives pin and loads C into A, every match.
// RQ2: Buffered capture loads counter into A and old A into C together.
// RQ3: PWM matches set pin low, high or toggle; duty 0 to 100 percent.
// RQ4: Channels pick PWM independently, sync works; clearing register sets period.
// RQ5: PWM1 pairs A-B and C-D; A/C levels at A/C matches, B/D levels at B/D matches, both on pin A/C.
// RQ6: PWM1 start level from A/C setting; equal pair values leave output unchanged.
// RQ7: PWM1 gives up to four independent phases across the unit.
// RQ8: PWM2 cycle register clears counter and returns all pins to initial level.
// RQ9: PWM2 duty equal to cycle value never changes that pin.
// RQ10: PWM2 with sync gives up to seven phases.
// RQ11: PWM1 uses ch0 pins A,C and ch1/2 pin A; PWM2 skips period pin.
// RQ12: Phase counting only on ch1/2, external up/down, other functions remain.
// RQ13: Counting down through zero sets the underflow flag.
// RQ14: Status holds a readable count direction flag.
// RQ15: Ch1 phases from external inputs A,B; ch2 from C,D.
// RQ16: Mode 1 counts all four edge cases up, complements down.
// RQ17: Mode 2 counts only A falling: up with B high, down with B low.
// RQ18: Mode 3 up on A falling with B high, down on B falling with A high.
// RQ19: Mode 4 counts B edges by A level; A edges ignored.
// RQ20: Counter wraps all ones to zero, sets overflow flag, requests interrupt.
// RQ21: Match as clear source sets compare flag, clears counter, counting resumes.
// RQ22: Software clears a flag by writing zero; its request then drops.
// RQ23: Phase inputs synchronised, edges from successive samples, one step per event.
// RQ24: On PWM1 clear the period match level applies before later duty matches.
`include "tbpc_map.svh"
module tbpc_unit (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Configuration, register writes, flag clears
	input tbpc_pkg::tbpc_cfg_t [2:0] cfg_i,
	input tbpc_pkg::tbpc_wr_t wr_i,
	input wire logic [2:0][5:0] flag_clr_i,
	// Pins from outside
	input wire logic [3:0] ext_clk_i,
	input wire logic [2:0][1:0] cap_i,
	// Pins, counters and status
	output logic [2:0][3:0] pin_o,
	output logic [2:0][15:0] cnt_o,
	output logic [2:0][3:0][15:0] gr_o,
	output tbpc_pkg::tbpc_stat_t [2:0] stat_o,
	output logic [2:0] irq_o
);
	import tbpc_pkg::*;

	tbpc_state_t s;
	tbpc_state_t n;
	logic [2:0] up;
	logic [2:0] dn;
	logic [2:0] own_clr;
	logic [2:0] clr;
	logic [2:0] syncm;
	logic [2:0][3:0] match;
	logic [2:0][3:0] capt;
	logic [1:0] step;
	logic ph;
	logic rise;
	logic fall;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic lvl_apply(input logic [1:0] lvl, input logic cur);
		case (lvl)
			`TBPC_LVL_LOW: lvl_apply = 1'b0;
			`TBPC_LVL_HIGH: lvl_apply = 1'b1;
			`TBPC_LVL_TOG: lvl_apply = ~cur;
			default: lvl_apply = cur;
		endcase
	endfunction

	// Returns {up, down} for one sample step of the two phases
	function automatic logic [1:0] phase_step(input logic [1:0] sel, input logic a,
			input logic b, input logic pa, input logic pb);
		logic ar, af, br, bf;
		ar = a & ~pa;
		af = ~a & pa;
		br = b & ~pb;
		bf = ~b & pb;
		case (sel)
			`TBPC_PH_M1: phase_step = {(br & a) | (bf & ~a) | (ar & ~b) | (af & b),
				(bf & a) | (br & ~a) | (af & ~b) | (ar & b)}; // [RQ16]
			`TBPC_PH_M2: phase_step = {af & b, af & ~b}; // [RQ17]
			`TBPC_PH_M3: phase_step = {af & b, bf & a}; // [RQ18]
			default: phase_step = {(br & a) | (bf & ~a), (bf & a) | (br & ~a)}; // [RQ19]
		endcase
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = s;
		up = '0;
		dn = '0;
		own_clr = '0;
		clr = '0;
		syncm = '0;
		match = '0;
		capt = '0;
		step = '0;
		ph = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		// Only the second stage reads the first stage
		n.ext_s[0] = ext_clk_i; // [RQ23]
		n.ext_s[1] = s.ext_s[0];
		n.ext = s.ext_s[1];
		n.cap_s[0] = cap_i;
		n.cap_s[1] = s.cap_s[0];
		n.cap = s.cap_s[1];
		for (int c = 0; c < 3; c++) begin
			// Channel 0 has no phase counting; it falls back to up-counting
			ph = (c > 0) && (cfg_i[c].mode == TBPC_PHASE); // [RQ12]
			// Channel 0 reads channel 1's inputs here, but ph keeps the result unused
			step = phase_step(cfg_i[c].phase_sel,
				s.ext_s[1][c == 2 ? 2 : 0], s.ext_s[1][c == 2 ? 3 : 1],
				s.ext[c == 2 ? 2 : 0], s.ext[c == 2 ? 3 : 1]); // [RQ15]
			// Opposite steps in one sample cancel, so the count moves by one at most
			up[c] = cfg_i[c].run & (ph ? step[1] & ~step[0] : 1'b1);
			dn[c] = cfg_i[c].run & ph & step[0] & ~step[1]; // [RQ23]
			syncm[c] = cfg_i[c].sync;
			for (int r = 0; r < 4; r++) begin
				if (r < 2 && cfg_i[c].cap_en[r]) begin
					rise = s.cap_s[1][c][r] & ~s.cap[c][r];
					fall = ~s.cap_s[1][c][r] & s.cap[c][r];
					capt[c][r] = (cfg_i[c].cap_edge[0] & rise) | (cfg_i[c].cap_edge[1] & fall);
				end else if (r < 2 || c == 0) begin
					match[c][r] = (up[c] | dn[c]) && (s.ch[c].cnt == s.ch[c].gr[r]);
				end
				if (cfg_i[c].clr_sel == 3'(r + 1) && (match[c][r] | capt[c][r])) begin
					own_clr[c] = 1'b1; // [RQ4]
				end
			end
		end
		for (int c = 0; c < 3; c++) begin
			clr[c] = own_clr[c] | ((cfg_i[c].clr_sel == `TBPC_CLR_SYNC) & syncm[c]
				& |(own_clr & syncm)); // [RQ4] [RQ10]
		end
		for (int c = 0; c < 3; c++) begin
			// Register and counter writes; a synced counter write presets all synced ones
			if (wr_i.we && wr_i.sel == `TBPC_SEL_CNT &&
					(wr_i.ch == 2'(c) || (syncm[c] && cfg_i[wr_i.ch].sync))) begin
				n.ch[c].cnt = wr_i.data;
			end else if (up[c]) begin
				n.ch[c].cnt = s.ch[c].cnt + 16'h0001; // [RQ20]
			end else if (dn[c]) begin
				n.ch[c].cnt = s.ch[c].cnt - 16'h0001;
			end
			// Clearing beats a counter write in the same cycle
			if (clr[c]) begin
				n.ch[c].cnt = `TBPC_CNT_RST; // [RQ21]
			end
			if (wr_i.we && wr_i.ch == 2'(c) && wr_i.sel < `TBPC_SEL_CNT
					&& (c == 0 || wr_i.sel < 3'h2)) begin
				n.ch[c].gr[wr_i.sel[1:0]] = wr_i.data;
			end
			for (int r = 0; r < 2; r++) begin
				if (capt[c][r]) begin
					n.ch[c].gr[r] = s.ch[c].cnt; // [RQ2]
					if (c == 0 && cfg_i[c].buf_en[r]) begin
						n.ch[c].gr[r+2] = s.ch[c].gr[r]; // [RQ2]
					end
				end
				if (match[c][r] && c == 0 && cfg_i[c].buf_en[r]) begin
					n.ch[c].gr[r] = s.ch[c].gr[r+2]; // [RQ1]
				end
			end
			// Flags: clear then set, so a new event wins over the clear
			n.ch[c].st.cmp = (s.ch[c].st.cmp & ~flag_clr_i[c][5:2]) | match[c] | capt[c]; // [RQ21]
			n.ch[c].st.ovf = (s.ch[c].st.ovf & ~flag_clr_i[c][1]) |
				(up[c] & ~clr[c] & (s.ch[c].cnt == `TBPC_CNT_MAX)); // [RQ20]
			n.ch[c].st.unf = (s.ch[c].st.unf & ~flag_clr_i[c][0]) |
				(dn[c] & ~clr[c] & (s.ch[c].cnt == `TBPC_CNT_RST)); // [RQ13]
			if (dn[c]) begin
				n.ch[c].st.dir = 1'b0; // [RQ14]
			end else if (up[c]) begin
				n.ch[c].st.dir = 1'b1; // [RQ14]
			end
			// Pins; a stopped channel rests at its initial levels
			if (!cfg_i[c].run) begin
				n.ch[c].pin = cfg_i[c].init_lvl; // [RQ6]
			end else begin
				case (cfg_i[c].mode)
					TBPC_PWM1: begin
						// Equal pair values match together and leave the pin alone
						for (int p = 0; p < 4; p += 2) begin
							if (p == 0 || c == 0) begin // [RQ7] [RQ11]
								if (match[c][p] && !match[c][p+1]) begin
									n.ch[c].pin[p] = lvl_apply(cfg_i[c].io_lvl[p], s.ch[c].pin[p]); // [RQ5]
								end else if (match[c][p+1] && !match[c][p]) begin
									n.ch[c].pin[p] = lvl_apply(cfg_i[c].io_lvl[p+1],
										s.ch[c].pin[p]); // [RQ24]
								end
							end
						end
					end
					TBPC_PWM2: begin
						if (clr[c]) begin
							n.ch[c].pin = cfg_i[c].init_lvl; // [RQ8] [RQ9]
						end else begin
							for (int r = 0; r < 4; r++) begin
								if (match[c][r] && cfg_i[c].clr_sel != 3'(r + 1)) begin // [RQ11]
									n.ch[c].pin[r] = lvl_apply(cfg_i[c].io_lvl[r], s.ch[c].pin[r]); // [RQ3]
								end
							end
						end
					end
					default: begin
						for (int r = 0; r < 4; r++) begin
							if (match[c][r]) begin
								n.ch[c].pin[r] = lvl_apply(cfg_i[c].io_lvl[r], s.ch[c].pin[r]); // [RQ3]
							end
						end
					end
				endcase
			end
			n.ch[c].irq = |({n.ch[c].st.cmp, n.ch[c].st.ovf, n.ch[c].st.unf}
				& cfg_i[c].irq_en); // [RQ20] [RQ22]
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s <= '0;
			for (int c = 0; c < 3; c++) begin
				for (int r = 0; r < 4; r++) begin
					s.ch[c].gr[r] <= `TBPC_GR_RST;
				end
				s.ch[c].st.dir <= 1'b1;
			end
		end else begin
			s <= n;
		end
	end

	always_comb begin
		for (int c = 0; c < 3; c++) begin
			pin_o[c] = s.ch[c].pin;
			cnt_o[c] = s.ch[c].cnt;
			gr_o[c] = s.ch[c].gr;
			stat_o[c] = s.ch[c].st;
			irq_o[c] = s.ch[c].irq;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	chk_ovf_wrap: assert property (up[0] && !clr[0] && !wr_i.we && s.ch[0].cnt == 16'hFFFF // [RQ20]
		|=> s.ch[0].cnt == 16'h0000 && s.ch[0].st.ovf) else $error("overflow wrap wrong");
	chk_unf_flag: assert property (dn[1] && !clr[1] && !wr_i.we && s.ch[1].cnt == 16'h0000 // [RQ13]
		|=> s.ch[1].cnt == 16'hFFFF && s.ch[1].st.unf) else $error("underflow not flagged");
	chk_cmp_clear: assert property (own_clr[0] && cfg_i[0].clr_sel == 3'h1 // [RQ21]
		|=> s.ch[0].cnt == 16'h0000 && s.ch[0].st.cmp[0]) else $error("match clear wrong");
	chk_buf_cmp: assert property (match[0][0] && cfg_i[0].buf_en[0] && !wr_i.we // [RQ1]
		|=> s.ch[0].gr[0] == $past(s.ch[0].gr[2])) else $error("compare buffer not moved");
	chk_buf_cap: assert property (capt[0][0] && cfg_i[0].buf_en[0] && !wr_i.we // [RQ2]
		|=> s.ch[0].gr[2] == $past(s.ch[0].gr[0]) && s.ch[0].gr[0] == $past(s.ch[0].cnt))
		else $error("capture buffer wrong");
	chk_pwm2_init: assert property (clr[0] && cfg_i[0].run && cfg_i[0].mode == TBPC_PWM2 // [RQ8]
		|=> s.ch[0].pin == $past(cfg_i[0].init_lvl)) else $error("pwm2 init level missed");
	chk_pwm1_equal: assert property (cfg_i[0].run && cfg_i[0].mode == TBPC_PWM1 // [RQ6]
		&& match[0][0] && match[0][1] |=> $stable(s.ch[0].pin[0])) else $error("pwm1 equal moved");
	chk_dir_down: assert property (dn[1] ##1 !up[1] |-> !s.ch[1].st.dir) // [RQ14]
		else $error("direction flag wrong");
	// Channel 0 has no phase inputs; asking for phase counting leaves it counting up
	chk_ch0_nophase: assert property (cfg_i[0].mode == TBPC_PHASE && cfg_i[0].run // [RQ12]
		|-> up[0] && !dn[0]) else $error("channel 0 counted down");
	chk_cap_setwins: assert property (capt[0][0] && flag_clr_i[0][2] // [RQ22]
		|=> s.ch[0].st.cmp[0]) else $error("capture flag lost to clear");
	// One step per qualifying sample; writes and clears override the step
	chk_step_up: assert property (up[1] && !clr[1] && !wr_i.we // [RQ23]
		|=> s.ch[1].cnt == $past(s.ch[1].cnt) + 16'h0001) else $error("count up step wrong");
	chk_step_down: assert property (dn[1] && !clr[1] && !wr_i.we // [RQ23]
		|=> s.ch[1].cnt == $past(s.ch[1].cnt) - 16'h0001) else $error("count down step wrong");
	chk_dir_up: assert property (up[1] |=> s.ch[1].st.dir) // [RQ14]
		else $error("direction flag not up");
	// A stopped channel is how the initial levels get onto the pins
	chk_stop_init: assert property (!cfg_i[0].run // [RQ6]
		|=> s.ch[0].pin == $past(cfg_i[0].init_lvl)) else $error("stopped pins not initial");
	// A counter write that meets a clear must lose, or the period slips
	chk_wr_clear: assert property (clr[0] && wr_i.we && wr_i.sel == 3'h4 // [RQ21]
		|=> s.ch[0].cnt == 16'h0000) else $error("write beat clear");
	chk_flag_setwins: assert property (match[0][1] && flag_clr_i[0][3] // [RQ22]
		|=> s.ch[0].st.cmp[1]) else $error("set lost to clear");

	// ----------------------------------------
	// Covers
	// ----------------------------------------
	// Main scenarios the bench is expected to reach
	cov_buf_cmp: cover property (match[0][0] && cfg_i[0].buf_en[0]);
	cov_phase_dn: cover property (dn[1] ##[1:20] dn[1]);
	cov_pwm1_clr: cover property (own_clr[0] && cfg_i[0].mode == TBPC_PWM1);
	cov_capture: cover property (capt[0][0]);
	cov_pwm2_clr: cover property (clr[0] && cfg_i[0].mode == TBPC_PWM2);
endmodule

// *** tb/tbpc_enc_model.sv ***
module tbpc_enc_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// One step request per encoder, up or down
	input wire logic [1:0] step_i,
	input wire logic [1:0] up_i,
	// Phases, A in the low bit of each pair
	output logic [3:0] ab_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [1:0][1:0] pos;

	// --------------------------------
	// Encoder position
	// --------------------------------
	// One edge per step, so the two phases never move together
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pos <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (step_i[i]) begin
					pos[i] <= up_i[i] ? pos[i] + 2'h1 : pos[i] - 2'h1;
				end
			end
		end
	end

	// Up order A,B: 00 10 11 01, so A leads B when turning up
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			ab_o[2*i +: 2] = {pos[i][1], pos[i][1] ^ pos[i][0]};
		end
	end
endmodule

// *** tb/test_timer_buffer_pwm_phase_count.sv ***
module test_timer_buffer_pwm_phase_count;
	timeunit 1ns;
	timeprecision 1ns;
	import tbpc_pkg::*;

	typedef struct packed {
		logic [1:0] sel;
		logic [15:0] k;
	} tbpc_row_t;

	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	tbpc_cfg_t [2:0] cfg = '0;
	tbpc_wr_t wr = '0;
	logic [2:0][5:0] flag_clr = '0;
	logic [1:0] step = '0;
	logic [1:0] up = '0;
	logic [3:0] ext;
	logic [2:0][1:0] cap = '0;
	logic [2:0][3:0] pin;
	logic [2:0][15:0] cnt;
	logic [2:0][3:0][15:0] gr;
	tbpc_stat_t [2:0] stat;
	logic [2:0] irq;
	logic [15:0] n;
	int errors = 0;
	int comparisons = 0;
	// Phase mode and counts per full encoder cycle
	tbpc_row_t rows [4] = '{'{2'h0, 16'h4}, '{2'h1, 16'h1}, '{2'h2, 16'h1}, '{2'h3, 16'h2}};

	always #5 clk_i = ~clk_i;

	tbpc_unit u_tbpc_unit (
		.clk_i(clk_i), .rstn_i(rstn_i), .cfg_i(cfg), .wr_i(wr), .flag_clr_i(flag_clr),
		.ext_clk_i(ext), .cap_i(cap), .pin_o(pin), .cnt_o(cnt), .gr_o(gr),
		.stat_o(stat), .irq_o(irq)
	);
	tbpc_enc_model u_tbpc_enc_model (
		.clk_i(clk_i), .rstn_i(rstn_i), .step_i(step), .up_i(up), .ab_o(ext)
	);

	// --------------------------------
	// Tasks
	// --------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic test_done();
		if (errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge clk_i);
	endtask

	// Steps spaced five cycles apart, well over the two-cycle minimum
	task automatic steps(input int ch, input logic dir, input int k);
		repeat (k) begin
			step[ch] = 1'b1;
			up[ch] = dir;
			cyc(1);
			step[ch] = 1'b0;
			cyc(4);
		end
	endtask

	task automatic wr_reg(input logic [1:0] ch, input logic [2:0] sel, input logic [15:0] d);
		wr = '{1'b1, ch, sel, d};
		cyc(1);
		wr = '0;
		// Idle edge, so a following write never reassigns the strobe at once
		cyc(1);
	endtask

	// High cycles of one pin over one ten-cycle period
	task automatic hi(input int c, input int p);
		n = 16'h0000;
		repeat (10) begin
			cyc(1);
			n = n + 16'(pin[c][p]);
		end
	endtask

	// --------------------------------
	// Sequence
	// --------------------------------
	initial begin
		cyc(3);
		rstn_i = 1'b1;
		cyc(1);
		check("reset count", cnt[1], 16'h0000);
		check("reset reg", gr[0][0], 16'hFFFF);
		check("reset dir", {15'h0, stat[1].dir}, 16'h0001);
		for (int r = 0; r < 4; r++) begin
			for (int c = 1; c < 3; c++) begin
				cfg[c].mode = TBPC_PHASE;
				cfg[c].run = 1'b1;
				cfg[c].phase_sel = rows[r].sel;
				wr_reg(c[1:0], 3'h4, 16'h0000);
			end
			flag_clr = {6'h01, 6'h01, 6'h00};
			cyc(1);
			flag_clr = '0;
			steps(0, 1'b1, 8);
			steps(1, 1'b0, 4);
			cyc(4);
			check("up count", cnt[1], rows[r].k << 1);
			check("other channel", cnt[2], 16'h0000 - rows[r].k);
			check("up dir", {15'h0, stat[1].dir}, 16'h0001);
			steps(0, 1'b0, 12);
			cyc(4);
			check("down count", cnt[1], 16'h0000 - rows[r].k);
			check("down dir", {15'h0, stat[1].dir}, 16'h0000);
			check("underflow", {15'h0, stat[1].unf}, 16'h0001);
		end
		cfg[0].run = 1'b1;
		cfg[0].irq_en = 6'h02;
		wr_reg(2'h0, 3'h4, 16'hFFFD);
		cyc(5);
		check("overflow", {15'h0, stat[0].ovf}, 16'h0001);
		check("overflow irq", {15'h0, irq[0]}, 16'h0001);
		flag_clr = {6'h00, 6'h00, 6'h02};
		cyc(1);
		flag_clr = '0;
		cyc(1);
		check("cleared irq", {15'h0, irq[0]}, 16'h0000);
		cfg[0].run = 1'b0;
		cfg[0].mode = TBPC_PWM1;
		cfg[0].clr_sel = 3'h2;
		cfg[0].io_lvl = {2'h0, 2'h0, 2'h1, 2'h2};
		cfg[0].buf_en = 2'h1;
		wr_reg(2'h0, 3'h0, 16'h0003);
		wr_reg(2'h0, 3'h1, 16'h0009);
		wr_reg(2'h0, 3'h2, 16'h0005);
		wr_reg(2'h0, 3'h4, 16'h0000);
		cfg[0].run = 1'b1;
		cyc(30);
		check("buffered a", gr[0][0], 16'h0005);
		hi(0, 0);
		check("pwm1 duty", n, 16'h0004);
		cfg[0].run = 1'b0;
		wr_reg(2'h0, 3'h0, 16'h0009);
		wr_reg(2'h0, 3'h2, 16'h0009);
		cfg[0].run = 1'b1;
		cyc(12);
		hi(0, 0);
		check("pwm1 equal", n, 16'h0000);
		cfg[0].run = 1'b0;
		cfg[0].mode = TBPC_PWM2;
		cfg[0].clr_sel = 3'h4;
		cfg[0].io_lvl = {2'h3, 2'h0, 2'h0, 2'h2};
		cfg[0].buf_en = 2'h0;
		wr_reg(2'h0, 3'h3, 16'h0009);
		wr_reg(2'h0, 3'h0, 16'h0003);
		wr_reg(2'h0, 3'h4, 16'h0000);
		cfg[0].run = 1'b1;
		cyc(20);
		hi(0, 0);
		check("pwm2 duty", n, 16'h0006);
		hi(0, 3);
		check("period pin", n, 16'h0000);
		// Captures 8 then 6 cycles apart, counter cleared by each capture
		cfg[0].mode = TBPC_PHASE;
		cfg[0].clr_sel = 3'h1;
		cfg[0].cap_en = 2'h1;
		cfg[0].cap_edge = 2'h3;
		cfg[0].buf_en = 2'h1;
		cap[0][0] = 1'b1;
		cyc(8);
		cap[0][0] = 1'b0;
		cyc(6);
		check("capture a", gr[0][0], 16'h0007);
		cap[0][0] = 1'b1;
		cyc(2);
		flag_clr = {6'h00, 6'h00, 6'h04};
		cyc(1);
		flag_clr = '0;
		cyc(2);
		check("capture new a", gr[0][0], 16'h0005);
		check("capture old a", gr[0][2], 16'h0007);
		check("flag set wins", {15'h0, stat[0].cmp[0]}, 16'h0001);
		flag_clr = {6'h00, 6'h00, 6'h04};
		cyc(1);
		flag_clr = '0;
		cyc(1);
		check("flag cleared", {15'h0, stat[0].cmp[0]}, 16'h0000);
		test_done();
	end

	// About 700 cycles expected; 5000 leaves ample margin
	initial begin
		#50000;
		errors++;
		test_done();
	end
endmodule
